// ===== dssp_chk.sv
// checker: timing relations on the serial port pins
// assumes: bound to dssp_serial_port, one core clock domain
`timescale 1ns/10ps
`default_nettype none
module dssp_chk #(
    parameter int ACC_W = 12
) (
    input wire logic             core_clk,
    input wire logic             rst,
    input wire logic             accel_select_n,
    input wire logic             temperature_select_n,
    input wire logic             dout_oe,
    input wire logic             sample_strobe,
    input wire logic [7:0]       ctrl_word,
    input wire logic             shutdown,
    input wire logic [ACC_W-1:0] accel_result
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // --------------------------------------------------------
    // assertions
    // --------------------------------------------------------
    // six cycles covers the two-flop sync plus the output register
    a_idle_released: assert property ((accel_select_n && temperature_select_n) [*6] |-> !dout_oe)
        else $error("data out driven outside a frame");
    a_frame_opens: assert property ($fell(accel_select_n) |-> ##[1:5] dout_oe)
        else $error("data out not driven after select");
    a_release_on_rise: assert property ($rose(accel_select_n) |-> ##[1:5] !dout_oe)
        else $error("data out not released after select rise");
    a_strobe_in_frame: assert property (sample_strobe |-> !accel_select_n)
        else $error("sample outside an accel frame");
    a_no_sample_down: assert property (sample_strobe |-> !shutdown)
        else $error("sample taken in shutdown");
    a_result_cause: assert property ($changed(accel_result) |-> sample_strobe)
        else $error("result changed without a sample");
    a_ctrl_in_frame: assert property ($changed(ctrl_word) |-> !accel_select_n && temperature_select_n)
        else $error("control word changed outside an accel frame");
    a_pdown_now: assert property ($rose(shutdown) |-> ctrl_word[0])
        else $error("shutdown without power-down bit");
endmodule
bind dssp_serial_port dssp_chk #(.ACC_W(ACC_W)) u_chk (.core_clk(core_clk), .rst(rst),
    .accel_select_n(accel_select_n), .temperature_select_n(temperature_select_n), .dout_oe(dout_oe),
    .sample_strobe(sample_strobe), .ctrl_word(ctrl_word), .shutdown(shutdown), .accel_result(accel_result));
`default_nettype wire

// ===== dssp_host.sv
// host model: drives both selects, the serial clock and data in
// assumes: data out is read only while its enable is high
`timescale 1ns/10ps
`default_nettype none
module dssp_host (
    output logic      sclk,
    output logic      accel_select_n,
    output logic      temperature_select_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    // --------------------------------------------------------
    // frame driver
    // --------------------------------------------------------
    initial begin
        sclk = 1'b0; // clock stands still between frames
        accel_select_n = 1'b1;
        temperature_select_n = 1'b1;
        din = 1'b0;
    end
    // released line reads as pulled up
    function automatic logic rd();
        return dout_oe ? dout : 1'b1;
    endfunction
    task automatic xfer(input bit acc, input logic [7:0] w, input int n, output logic [15:0] q);
        q = 16'h0;
        #7;
        if (acc) accel_select_n = 1'b0;
        else temperature_select_n = 1'b0;
        #24;
        for (int i = 0; i < 16 * n; i++) begin
            din = (acc && i % 16 < 8) ? w[7 - i % 16] : 1'b0;
            #24 sclk = 1'b1;
            #24;
            if (i % 16 > 0) q = {q[14:0], rd()};
            sclk = 1'b0;
        end
        #48 q = {q[14:0], rd()};
        accel_select_n = 1'b1;
        temperature_select_n = 1'b1;
        #48;
    endtask
endmodule
`default_nettype wire

// ===== dssp_pkg.sv
// dssp_pkg: constants shared by the dual-select sensor serial port
// assumes: one core clock domain; serial pins arrive asynchronously
//
// How it works
// - a low temperature select frames a transfer of the temperature result on the shared data output.
// - each output bit is shifted onto the data output on a falling serial clock edge.
// - data input bits are captured into the control register on rising serial clock edges of an acceleration frame.
// - a low acceleration select both starts a conversion and frames the transfer of its result.
// - the serial clock alone steps the acceleration conversion; no other conversion clock exists.
// - a high self-test input shifts the reported acceleration by about 614 LSB; low means no self-test.
// - the selected axis is sampled on the second rising serial clock edge after the select falls.
// - each acceleration conversion takes 16 serial clock cycles.
// - the rising edge of the acceleration select releases the data output to high impedance.
// - if the acceleration select stays low after 16 clocks the next conversion starts at once.
// - the data output carries acceleration data under one select and temperature data under the other.
// - control word bit 3 chooses the axis, 0 for x and 1 for y, for the following conversion.
// - control bit 0 high shuts the path down at once; written low it restores on the 16th rising edge.
// - a temperature read is 16 clocks: a leading zero then ten result bits, data input held low.
package dssp_pkg;
    // ------------------------------------------------------------
    // frame and field layout
    // ------------------------------------------------------------
    localparam int        FRAME_CLKS     = 16;
    localparam int        CNT_W          = 4;
    localparam int        SAMPLE_EDGE    = 2;
    localparam int        CTRL_W         = 8;
    localparam int        AXIS_BIT       = 3;
    localparam int        PDOWN_BIT      = 0;
    localparam int        ACC_W          = 12;
    localparam int        TEMP_W         = 10;
    localparam int        ACC_LEAD       = 4;
    localparam int        TEMP_LEAD      = 1;
    localparam logic [11:0] SELF_TEST_LSB = 12'h266;
    localparam logic [7:0]  CTRL_RESET    = 8'h04;
endpackage

// ===== dssp_serial_port.sv
// dssp_serial_port: device end of the dual-select sensor serial port
// assumes: serial clock well below core_clk/4; sample values come from the analog side as ports
`timescale 1ns/10ps
`default_nettype none
module dssp_serial_port #(
    parameter int ACC_W  = dssp_pkg::ACC_W,
    parameter int TEMP_W = dssp_pkg::TEMP_W
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              sclk,
    input  wire logic              accel_select_n,
    input  wire logic              temperature_select_n,
    input  wire logic              din,
    input  wire logic              self_test_input,
    input  wire logic [ACC_W-1:0]  x_sample,
    input  wire logic [ACC_W-1:0]  y_sample,
    input  wire logic [TEMP_W-1:0] temp_result,
    output logic                   dout,
    output logic                   dout_oe,
    output logic [7:0]             ctrl_word,
    output logic                   shutdown,
    output logic                   sample_strobe,
    output logic [ACC_W-1:0]       accel_result
);
    if (ACC_W + dssp_pkg::ACC_LEAD != dssp_pkg::FRAME_CLKS ||
        TEMP_W + dssp_pkg::TEMP_LEAD > dssp_pkg::FRAME_CLKS) begin : g_bad_width
        $error("result widths do not fit a 16 clock frame");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pins_s;
    // sclk enters inverted so the flops' reset value matches its idle low level: no false edge
    dssp_sync #(.W(5)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({~sclk, accel_select_n, temperature_select_n, din, self_test_input}),
        .q        (pins_s)
    );
    logic sclk_n_s;
    logic sclk_s;
    logic acs_n_s;
    logic tcs_n_s;
    logic din_s;
    logic st_s;
    assign {sclk_n_s, acs_n_s, tcs_n_s, din_s, st_s} = pins_s;
    assign sclk_s = ~sclk_n_s;

    // ------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IDLE  = 3'b001,
        ACCEL = 3'b010,
        TEMP  = 3'b100
    } dssp_state_t;

    dssp_state_t            st_r, st_nxt;
    logic                   sclk_d_r, sclk_d_nxt;
    logic [dssp_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [15:0]            sh_r, sh_nxt;
    logic [7:0]             rx_r, rx_nxt;
    logic [7:0]             ctrl_r, ctrl_nxt;
    logic                   pd_r, pd_nxt;
    logic                   dout_r, dout_nxt;
    logic                   oe_r, oe_nxt;
    logic                   strb_r, strb_nxt;
    logic                   run_r, run_nxt;
    logic [ACC_W-1:0]       acc_r, acc_nxt;
    logic                   rise;
    logic                   fall;
    logic [ACC_W-1:0]       raw;
    logic [7:0]             word;

    assign rise = sclk_s & ~sclk_d_r;
    assign fall = ~sclk_s & sclk_d_r;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------

    always_comb begin
        st_nxt     = st_r;
        sclk_d_nxt = sclk_s;
        cnt_nxt    = cnt_r;
        sh_nxt     = sh_r;
        rx_nxt     = rx_r;
        ctrl_nxt   = ctrl_r;
        pd_nxt     = pd_r;
        dout_nxt   = dout_r;
        oe_nxt     = oe_r;
        strb_nxt   = 1'b0;
        run_nxt    = run_r;
        acc_nxt    = acc_r;
        word       = {rx_r[6:0], din_s};
        // test stimulus adds a fixed offset to the reading
        raw        = ctrl_r[dssp_pkg::AXIS_BIT] ? y_sample : x_sample;
        if (st_s) begin
            raw = raw + ACC_W'(dssp_pkg::SELF_TEST_LSB);
        end
        unique case (st_r)
            IDLE: begin
                oe_nxt  = 1'b0;
                cnt_nxt = '0;
                run_nxt = 1'b0;
                if (!acs_n_s) begin
                    st_nxt = ACCEL;
                    oe_nxt = 1'b1;
                    dout_nxt = 1'b0;
                    sh_nxt = '0;
                end else if (!tcs_n_s) begin
                    st_nxt = TEMP;
                    oe_nxt = 1'b1;
                    dout_nxt = 1'b0;
                    // leading zero, result, then pad
                    sh_nxt = 16'({1'b0, temp_result}) << (16 - TEMP_W - dssp_pkg::TEMP_LEAD);
                end
            end
            ACCEL: begin
                if (acs_n_s) begin
                    st_nxt = IDLE;
                    oe_nxt = 1'b0;
                end else begin
                    if (rise) begin
                        // conversion stepped only by serial clock edges
                        cnt_nxt = cnt_r + 1'b1;
                        rx_nxt  = word;
                        run_nxt = 1'b1;
                        if (cnt_r == 4'(dssp_pkg::SAMPLE_EDGE - 1) && !pd_r) begin
                            // one pad bit below the result so its lsb leaves on the 16th fall
                            sh_nxt   = 16'({raw, 1'b0});
                            acc_nxt  = raw;
                            strb_nxt = 1'b1;
                        end
                        if (cnt_r == 4'(dssp_pkg::CTRL_W - 1)) begin
                            ctrl_nxt = word;
                            if (word[dssp_pkg::PDOWN_BIT]) begin
                                pd_nxt = 1'b1;
                            end
                        end
                        if (cnt_r == 4'(dssp_pkg::FRAME_CLKS - 1)) begin
                            cnt_nxt = '0;
                            if (!ctrl_r[dssp_pkg::PDOWN_BIT]) begin
                                pd_nxt = 1'b0;
                            end
                        end
                    end
                    if (fall && run_r) begin
                        dout_nxt = sh_r[15];
                        sh_nxt   = {sh_r[14:0], 1'b0};
                    end
                end
            end
            TEMP: begin
                if (tcs_n_s) begin
                    st_nxt = IDLE;
                    oe_nxt = 1'b0;
                end else begin
                    if (rise) begin
                        cnt_nxt = cnt_r + 1'b1;
                        run_nxt = 1'b1;
                    end
                    // last bit holds until the select rises
                    if (fall && run_r) begin
                        dout_nxt = sh_r[15];
                        sh_nxt   = {sh_r[14:0], 1'b0};
                    end
                end
            end
            default: begin
                st_nxt = IDLE;
                oe_nxt = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r     <= IDLE;
            sclk_d_r <= 1'b0;
            cnt_r    <= '0;
            sh_r     <= '0;
            rx_r     <= '0;
            ctrl_r   <= dssp_pkg::CTRL_RESET;
            pd_r     <= 1'b0;
            dout_r   <= 1'b0;
            oe_r     <= 1'b0;
            strb_r   <= 1'b0;
            run_r    <= 1'b0;
            acc_r    <= '0;
        end else begin
            st_r     <= st_nxt;
            sclk_d_r <= sclk_d_nxt;
            cnt_r    <= cnt_nxt;
            sh_r     <= sh_nxt;
            rx_r     <= rx_nxt;
            ctrl_r   <= ctrl_nxt;
            pd_r     <= pd_nxt;
            dout_r   <= dout_nxt;
            oe_r     <= oe_nxt;
            strb_r   <= strb_nxt;
            run_r    <= run_nxt;
            acc_r    <= acc_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    assign dout          = dout_r;
    assign dout_oe       = oe_r;
    assign ctrl_word     = ctrl_r;
    assign shutdown      = pd_r;
    assign sample_strobe = strb_r;
    assign accel_result  = acc_r;
endmodule
`default_nettype wire

// ===== dssp_sync.sv
// dssp_sync: two-flop synchroniser, one per bit
// assumes: inputs asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module dssp_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] q_nxt;
    always_comb begin
        s1_nxt = d;
        q_nxt  = s1_r;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_r <= '1;
            q    <= '1;
        end else begin
            s1_r <= s1_nxt;
            q    <= q_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== dual_select_sensor_serial_port_tb_top.sv
// bench: random accel and temperature frames against a behavioural model
// assumes: dssp_host on the serial pins, 200 MHz core clock
`timescale 1ns/10ps
`default_nettype none
module dual_select_sensor_serial_port_tb_top;
    logic        core_clk, rst, sclk, acc_n, tmp_n, din, st, dout, dout_oe, shutdown, strobe;
    logic [11:0] xs, ys, res, m_res;
    logic [9:0]  ts;
    logic [7:0]  ctrl, m_ctrl;
    int          n_mismatch = 0, comparisons = 0, n_strobe = 0, m_str = 0, m_down = 0;
    dssp_serial_port i_dut (.core_clk(core_clk), .rst(rst), .sclk(sclk), .accel_select_n(acc_n),
        .temperature_select_n(tmp_n), .din(din), .self_test_input(st), .x_sample(xs), .y_sample(ys),
        .temp_result(ts), .dout(dout), .dout_oe(dout_oe), .ctrl_word(ctrl), .shutdown(shutdown),
        .sample_strobe(strobe), .accel_result(res));
    dssp_host i_host (.sclk(sclk), .accel_select_n(acc_n), .temperature_select_n(tmp_n), .din(din),
        .dout(dout), .dout_oe(dout_oe));
    // --------------------------------------------------------
    // clock, compare and verdict
    // --------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (strobe === 1'b1) n_strobe++;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one frame of n conversions; model steps once per conversion
    task automatic frame(input bit acc, input int n);
        logic [7:0]  w;
        logic [15:0] q;
        bit          smp;
        @(negedge core_clk);
        xs = 12'($urandom);
        ys = 12'($urandom);
        ts = 10'($urandom);
        st = 1'($urandom);
        w = {1'($urandom), 3'h0, 1'($urandom), 2'b10, ($urandom_range(3) == 0)};
        i_host.xfer(acc, w, n, q);
        smp = (m_down == 0);
        for (int k = 0; k < n && acc; k++) begin
            if (m_down == 0) begin
                m_res = (m_ctrl[3] ? ys : xs) + (st ? dssp_pkg::SELF_TEST_LSB : 12'h0);
                m_str++;
            end
            m_ctrl = w;
            m_down = w[0]; // restore lands on the 16th rise
        end
        if (acc && n == 1 && smp) chk("accel_word", {4'h0, m_res}, q);
        if (!acc) chk("temp_word", {1'b0, ts, 5'h0}, q);
        chk("result", 16'(m_res), 16'(res));
        chk("ctrl", 16'(m_ctrl), 16'(ctrl));
        chk("shutdown", 16'(m_down), 16'(shutdown));
        chk("strobes", 16'(m_str), 16'(n_strobe));
    endtask
    // --------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------
    initial begin
        rst = 1'b1;
        st = 1'b0;
        xs = 12'h0;
        ys = 12'h0;
        ts = 10'h0;
        m_res = 12'h0;
        m_ctrl = 8'h04;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("ctrl_reset", 16'h0004, 16'(ctrl));
        void'($urandom(32'h162d));
        repeat (24) frame(1'($urandom), 1);
        // reset again between frames: model ctrl, shutdown and result return to their reset values
        @(negedge core_clk) rst = 1'b1;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        m_ctrl = dssp_pkg::CTRL_RESET;
        m_down = 0;
        m_res = 12'h0;
        repeat (4) @(negedge core_clk);
        chk("ctrl_reset", 16'(dssp_pkg::CTRL_RESET), 16'(ctrl));
        chk("shutdown", 16'(m_down), 16'(shutdown));
        chk("result", 16'(m_res), 16'(res));
        repeat (6) frame(1'($urandom), 1);
        frame(1'b1, 2);
        frame(1'b1, 3);
        finish_test();
    end
    initial begin
        #200us;
        n_mismatch++;
        finish_test();
    end
endmodule
`default_nettype wire
